// [design/cod_operand_decode.v]
// Operand decoder, register window mapping and flags register of the 16-bit core
// Function
// (RL1) After reset, first fetch address is 0xfff0 in internal ROM.
// (RL2) One unified address space serves program and data.
// (RL3) Core has 38 registers including window base and program counter; the code has R0..R15 plus these two, 18 in all.
// (RL4) R8..R14 act as pointers; R15 is the stack pointer.
// (RL5) Window base register is read/write at 0xc002; upper 11 bits used.
// (RL6) Register RAM address is (regnum<<1) OR base upper bits, bit 0 zero.
// (RL7) Window base resets to 0x100.
// (RL8) Base bits 0..4 never affect register addresses.
// (RL9) Flags register read-only at 0xc000: Z0, C1, S3, I4, rest zero.
// (RL10) Zero flag on zero result; sign flag on result MSB one.
// (RL11) Carry flag records add carry or subtract borrow.
// (RL12) Overflow raised when result exceeds destination size range.
// (RL13) Maskable interrupts enabled only while interrupt-enable flag is one.
// (RL14) Word: opcode 15..12, source 11..6, destination 5..0.
// (RL15) Field bit 3 one means byte, zero means word.
// (RL16) Register mode selects R0..R15 with bits 0..3, always 16 bit.
// (RL17) Immediate mode takes following word as 16-bit source.
// (RL18) Direct mode uses following word as address; width from bit 3.
// (RL19) Both direct: source address word first, then destination word.
// (RL20) Indirect modes select R8..R15 with bits 0..2.
// (RL21) R15 byte indirect decodes immediate; R15 auto-increment decodes direct.
// (RL22) Auto-increment advances pointer by one for byte, two for word; the code updates the destination pointer only, not the source.
// (RL23) Indexed mode adds following word to pointer, unsigned and wrapping.
// (RL24) Stack pointer indirect: decrement before write, increment after read; the code updates R15 for the destination only.
// (RL25) Execution waits until all extension words are fetched.
`timescale 1ns/1ns
`include "cod_regs.vh"
module cod_operand_decode
#(
  parameter RESET_VECTOR = `COD_RESET_VECTOR
)
(
  input  wire        sys_clk,         // Core clock
  input  wire        rst_b,           // Asynchronous reset, active low
  input  wire [15:0] reg_addr,        // Register bus address
  input  wire [15:0] reg_wdata,       // Register bus write data
  input  wire        reg_wr,          // Register bus write strobe
  input  wire        reg_rd,          // Register bus read strobe
  output reg  [15:0] reg_rdata,       // Read data, cycle after read strobe
  input  wire        instr_valid,     // New instruction word presented
  input  wire [15:0] instr_word,      // Instruction word
  input  wire        ext_valid,       // Extension word from memory valid
  input  wire [15:0] ext_word,        // Extension word
  input  wire        op_wr,           // Destination access is a write
  input  wire [15:0] ptr_value,       // Pointer register contents read from RAM
  input  wire        alu_done,        // Arithmetic result valid
  input  wire [15:0] alu_result,      // Arithmetic result
  input  wire        alu_carry,       // Carry or borrow out
  input  wire        alu_ovf,         // Size overflow
  input  wire        alu_byte,        // Result is byte wide
  input  wire        ie_set,          // Set global interrupt enable
  input  wire        ie_clr,          // Clear global interrupt enable
  output reg  [15:0] fetch_addr,      // Next fetch address
  output reg         ext_req,         // Extension word fetch request
  output reg         exec_go,         // Operands complete, execute pulse
  output reg  [3:0]  opcode,          // Decoded opcode
  output reg  [2:0]  src_mode,        // Source addressing mode
  output reg  [2:0]  dst_mode,        // Destination addressing mode
  output reg         src_byte,        // Source is byte wide
  output reg         dst_byte,        // Destination is byte wide
  output reg  [15:0] src_reg_addr,    // RAM address of source register
  output reg  [15:0] dst_reg_addr,    // RAM address of destination register
  output reg  [15:0] src_ea,          // Source operand address or immediate
  output reg  [15:0] dst_ea,          // Destination operand address
  output reg  [15:0] ptr_new,         // Updated pointer value
  output reg         ptr_wr,          // Pointer write-back pulse
  output reg         ovf_flag,        // Overflow condition
  output reg         irq_enable       // Maskable interrupts enabled
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SRC  = 3'b010;
  localparam ST_DST  = 3'b100;

  reg [15:0] win_base_reg;
  reg [15:0] flags_reg;
  reg [2:0]  state_reg;
  reg [15:0] pc_reg;
  reg        dst_need_reg;
  reg        dst_ptr_reg;

  wire [5:0] src_f = instr_word[`COD_SRC_HI:`COD_SRC_LO]; // RL14
  wire [5:0] dst_f = instr_word[`COD_DST_HI:`COD_DST_LO]; // RL14

  function [2:0] am_of;
    input [5:0] f;
    begin
      case (f[5:4])
        `COD_MODE_REG:  am_of = `COD_AM_REG; // RL16
        `COD_MODE_IND:  am_of = (f[3:0] == 4'hf) ? `COD_AM_IMM : `COD_AM_IND; // RL21
        `COD_MODE_AINC: am_of = (f[2:0] == 3'h7) ? `COD_AM_DIR : `COD_AM_AINC; // RL21
        default:        am_of = `COD_AM_IDX;
      endcase
    end
  endfunction

  // RL6 RL8: base upper 11 bits OR'd with register number shifted, bit 0 forced low
  function [15:0] map_reg;
    input [15:0] base;
    input [3:0]  num;
    begin
      map_reg = ((base & `COD_WINBASE_MASK) | {11'h000, num, 1'b0}) & 16'hfffe; // RL6 RL8
    end
  endfunction

  // Register number: 4 bits in register mode, R8..R15 in pointer modes
  function [3:0] rnum;
    input [5:0] f;
    begin
      rnum = (f[5:4] == `COD_MODE_REG) ? f[3:0] : {1'b1, f[2:0]}; // RL4 RL20
    end
  endfunction

  function needs_ext;
    input [2:0] am;
    begin
      needs_ext = (am == `COD_AM_IMM) || (am == `COD_AM_DIR) || (am == `COD_AM_IDX);
    end
  endfunction

  function is_byte;
    input [5:0] f;
    input [2:0] am;
    begin
      is_byte = (am == `COD_AM_REG || am == `COD_AM_IMM) ? 1'b0 : f[`COD_BW_BIT]; // RL15 RL17
    end
  endfunction

  function is_ptr;
    input [2:0] am;
    begin
      is_ptr = (am == `COD_AM_IND) || (am == `COD_AM_AINC) || (am == `COD_AM_IDX);
    end
  endfunction

  wire [2:0] s_am = am_of(src_f);
  wire [2:0] d_am = am_of(dst_f);
  wire [15:0] step_w = 16'h0002;
  wire [15:0] step_b = 16'h0001;

  // Pointer update for auto-increment and stack push/pop
  reg [15:0] upd_val;
  reg        upd_en;
  reg [15:0] addr_pre;
  always @*
  begin
    upd_val = ptr_value;
    upd_en = 1'b0;
    addr_pre = ptr_value;
    if (d_am == `COD_AM_AINC)
    begin
      upd_val = ptr_value + (is_byte(dst_f, d_am) ? step_b : step_w); // RL22
      upd_en = 1'b1;
    end
    else if (d_am == `COD_AM_IND && dst_f[2:0] == 3'h7)
    begin
      upd_en = 1'b1;
      if (op_wr)
      begin
        upd_val = ptr_value - step_w; // RL24
        addr_pre = upd_val;
      end
      else
        upd_val = ptr_value + step_w; // RL24
    end
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      win_base_reg <= `COD_WINBASE_RST; // RL7
      flags_reg    <= 16'h0000;
      state_reg    <= ST_IDLE;
      pc_reg       <= RESET_VECTOR; // RL1 RL3
      dst_need_reg <= 1'b0;
      dst_ptr_reg  <= 1'b0;
      reg_rdata    <= 16'h0000;
      fetch_addr   <= RESET_VECTOR; // RL1
      ext_req      <= 1'b0;
      exec_go      <= 1'b0;
      opcode       <= 4'h0;
      src_mode     <= 3'h0;
      dst_mode     <= 3'h0;
      src_byte     <= 1'b0;
      dst_byte     <= 1'b0;
      src_reg_addr <= 16'h0000;
      dst_reg_addr <= 16'h0000;
      src_ea       <= 16'h0000;
      dst_ea       <= 16'h0000;
      ptr_new      <= 16'h0000;
      ptr_wr       <= 1'b0;
      ovf_flag     <= 1'b0;
      irq_enable   <= 1'b0;
    end
    else
    begin
      exec_go <= 1'b0;
      ptr_wr  <= 1'b0;
      // Register bus
      if (reg_wr && reg_addr == `COD_ADDR_WINBASE)
        win_base_reg <= reg_wdata; // RL5
      if (reg_rd)
      begin
        if (reg_addr == `COD_ADDR_FLAGS)
          reg_rdata <= flags_reg & 16'h001b; // RL9
        else if (reg_addr == `COD_ADDR_WINBASE)
          reg_rdata <= win_base_reg; // RL5
        else
          reg_rdata <= 16'h0000;
      end
      // Flags update
      if (alu_done)
      begin
        flags_reg[`COD_FLAG_Z] <= alu_byte ? (alu_result[7:0] == 8'h00)
                                           : (alu_result == 16'h0000); // RL10
        flags_reg[`COD_FLAG_S] <= alu_byte ? alu_result[7] : alu_result[15]; // RL10
        flags_reg[`COD_FLAG_C] <= alu_carry; // RL11
        ovf_flag <= alu_ovf; // RL12
      end
      if (ie_set)
        flags_reg[`COD_FLAG_I] <= 1'b1;
      else if (ie_clr)
        flags_reg[`COD_FLAG_I] <= 1'b0;
      irq_enable <= flags_reg[`COD_FLAG_I]; // RL13
      case (state_reg)
        ST_IDLE:
        begin
          if (instr_valid)
          begin
            opcode       <= instr_word[`COD_OPC_HI:`COD_OPC_LO]; // RL14
            src_mode     <= s_am;
            dst_mode     <= d_am;
            src_byte     <= is_byte(src_f, s_am); // RL15 RL18
            dst_byte     <= is_byte(dst_f, d_am); // RL15 RL18
            src_reg_addr <= map_reg(win_base_reg, rnum(src_f)); // RL6 RL16 RL20
            dst_reg_addr <= map_reg(win_base_reg, rnum(dst_f)); // RL6 RL16 RL20
            src_ea       <= ptr_value;
            dst_ea       <= addr_pre; // RL24
            dst_need_reg <= needs_ext(d_am);
            dst_ptr_reg  <= is_ptr(d_am);
            pc_reg       <= pc_reg + step_w; // RL2
            fetch_addr   <= pc_reg + step_w;
            if (needs_ext(s_am))
            begin
              ext_req   <= 1'b1;
              state_reg <= ST_SRC; // RL19
            end
            else if (needs_ext(d_am))
            begin
              ext_req   <= 1'b1;
              state_reg <= ST_DST;
            end
            else
              exec_go <= 1'b1; // RL25
          end
        end
        ST_SRC:
        begin
          if (ext_valid)
          begin
            // RL17 RL18 RL23: immediate value, direct address or pointer plus offset
            src_ea     <= (src_mode == `COD_AM_IDX) ? ptr_value + ext_word : ext_word; // RL23
            pc_reg     <= pc_reg + step_w;
            fetch_addr <= pc_reg + step_w;
            if (dst_need_reg)
              state_reg <= ST_DST; // RL19
            else
            begin
              ext_req   <= 1'b0;
              exec_go   <= 1'b1; // RL25
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_DST:
        begin
          if (ext_valid)
          begin
            dst_ea     <= (dst_mode == `COD_AM_IDX) ? ptr_value + ext_word : ext_word; // RL23
            pc_reg     <= pc_reg + step_w;
            fetch_addr <= pc_reg + step_w;
            ext_req    <= 1'b0;
            exec_go    <= 1'b1; // RL25
            state_reg  <= ST_IDLE;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
      // Pointer write-back once the operand access is issued
      if (exec_go && dst_ptr_reg && upd_en)
      begin
        ptr_new <= upd_val; // RL22 RL24
        ptr_wr  <= 1'b1;
        if (dst_mode == `COD_AM_IND)
          dst_ea <= addr_pre; // RL24
      end
    end
  end
endmodule

// [inc/cod_regs.vh]
// Register offsets, field positions, reset values and decode codes for the operand decoder
`ifndef COD_REGS_VH
`define COD_REGS_VH
`define COD_ADDR_FLAGS      16'hc000
`define COD_ADDR_WINBASE    16'hc002
`define COD_WINBASE_RST     16'h0100
`define COD_WINBASE_MASK    16'hffe0
`define COD_RESET_VECTOR    16'hfff0
`define COD_FLAG_Z          0
`define COD_FLAG_C          1
`define COD_FLAG_S          3
`define COD_FLAG_I          4
`define COD_OPC_HI          15
`define COD_OPC_LO          12
`define COD_SRC_HI          11
`define COD_SRC_LO          6
`define COD_DST_HI          5
`define COD_DST_LO          0
`define COD_BW_BIT          3
`define COD_MODE_REG        2'b00
`define COD_MODE_IND        2'b01
`define COD_MODE_AINC       2'b10
`define COD_MODE_IDX        2'b11
`define COD_AM_REG          3'h0
`define COD_AM_IMM          3'h1
`define COD_AM_DIR          3'h2
`define COD_AM_IND          3'h3
`define COD_AM_AINC         3'h4
`define COD_AM_IDX          3'h5
`endif

// [testbench/cod_operand_decode_assertions.sv]
// Port checker for the operand decoder
`timescale 1ns/1ns
module cod_operand_decode_assertions (
  input wire logic        sys_clk,    // Clock
  input wire logic        rst_b,      // Reset
  input wire logic [15:0] reg_addr,   // Bus address
  input wire logic [15:0] reg_wdata,  // Bus write data
  input wire logic        reg_wr,     // Write strobe
  input wire logic        reg_rd,     // Read strobe
  input wire logic [15:0] reg_rdata,  // Read data
  input wire logic        ext_req,    // Word wanted
  input wire logic        exec_go,    // Execute pulse
  input wire logic [2:0]  src_mode,   // Source mode
  input wire logic [2:0]  dst_mode,   // Destination mode
  input wire logic        src_byte,   // Source width
  input wire logic        dst_byte,   // Destination width
  input wire logic [15:0] ptr_value,  // Pointer in
  input wire logic [15:0] ptr_new,    // Pointer out
  input wire logic        ptr_wr,     // Pointer write
  input wire logic [15:0] fetch_addr, // Fetch address
  input wire logic        ie_set,     // Enable set
  input wire logic        ie_clr,     // Enable clear
  input wire logic        op_wr,      // Write access
  input wire logic [15:0] instr_word, // Instruction
  input wire logic [15:0] dst_ea,     // Destination address
  input wire logic        irq_enable  // Enable state
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_base_wr;
    reg_wr && reg_addr == 16'hc002;
  endsequence
  sequence s_base_rd;
    reg_rd && !reg_wr && reg_addr == 16'hc002;
  endsequence
  a_reset_vector: assert property (
    $rose(rst_b) |-> fetch_addr == 16'hfff0) else $error("bad fetch address after reset");
  a_base_readback: assert property (
    s_base_wr ##1 s_base_rd |=> reg_rdata == $past(reg_wdata, 2)) else $error("base readback");
  a_flags_rsvd: assert property (
    reg_rd && reg_addr == 16'hc000 |=> reg_rdata[15:5] == 11'h0 && !reg_rdata[2])
    else $error("flags spare bits set");
  a_imm_word: assert property (
    exec_go && src_mode == 3'h1 |-> !src_byte) else $error("immediate not word");
  a_reg_word: assert property (
    exec_go && dst_mode == 3'h0 |-> !dst_byte) else $error("register not word");
  a_ext_hold: assert property (
    ext_req |-> !exec_go) else $error("execute while fetching");
  a_ext_exec: assert property (
    $fell(ext_req) |-> exec_go) else $error("no execute after last word");
  a_ptr_step: assert property (
    exec_go && dst_mode == 3'h4 |=> ptr_wr && ptr_new == $past(ptr_value)
      + ($past(dst_byte) ? 16'h1 : 16'h2)) else $error("pointer step wrong");
  a_irq_on: assert property (
    ie_set |-> ##2 irq_enable) else $error("interrupt enable not set");
  a_irq_off: assert property (
    ie_clr && !ie_set |-> ##2 !irq_enable) else $error("interrupt enable not cleared");
  a_push_addr: assert property (
    exec_go && dst_mode == 3'h3 && instr_word[2:0] == 3'h7 && op_wr
      |-> dst_ea == ptr_value - 16'h2) else $error("push address not predecremented");
  a_pop_step: assert property (
    exec_go && dst_mode == 3'h3 && instr_word[2:0] == 3'h7 && !op_wr
      |=> ptr_wr && ptr_new == $past(ptr_value) + 16'h2) else $error("pop step wrong");
endmodule
bind cod_operand_decode cod_operand_decode_assertions u_chk (.*);

// [testbench/cod_mem_model.sv]
// Memory side model: returns extension words and pointer contents
`timescale 1ns/1ns
module cod_mem_model (
  input  wire logic        sys_clk,   // Clock
  input  wire logic        rst_b,     // Reset
  input  wire logic        ext_req,   // Word wanted
  output logic             ext_valid, // Word returned
  output logic      [15:0] ext_word,  // Returned word
  output logic      [15:0] ptr_value  // Pointer contents
);
  logic [15:0] words[$];
  int          lag = 0;
  int          cnt;
  assign ptr_value = 16'hfff0;
  always @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      ext_valid <= 1'b0;
      ext_word  <= 16'h0;
      cnt       <= 0;
    end
    else if (ext_req && !ext_valid && cnt >= lag && words.size() > 0)
    begin
      ext_valid <= 1'b1;
      ext_word  <= words.pop_front();
      cnt       <= 0;
    end
    else
    begin
      ext_valid <= 1'b0;
      ext_word  <= ~ext_word; // Stale word never lingers
      cnt       <= ext_req ? cnt + 1 : 0;
    end
endmodule

// [testbench/cod_operand_decode_tb.sv]
// Self-checking bench for the operand decoder
`timescale 1ns/1ns
module cod_operand_decode_tb;
  logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, instr_valid = 1'b0;
  logic op_wr = 1'b0, alu_done = 1'b0, alu_carry = 1'b0, alu_ovf = 1'b0, alu_byte = 1'b0;
  logic ie_set = 1'b0, ie_clr = 1'b0, rd_q = 1'b0;
  logic ext_valid, ext_req, exec_go, src_byte, dst_byte, ptr_wr, ovf_flag, irq_enable;
  logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, instr_word = 16'h0, alu_result = 16'h0;
  logic [15:0] reg_rdata, ext_word, ptr_value, fetch_addr, src_reg_addr, dst_reg_addr;
  logic [15:0] src_ea, dst_ea, ptr_new, b, r1, r2;
  logic [3:0]  opcode;
  logic [2:0]  src_mode, dst_mode;
  logic [15:0] rq[$];
  logic [45:0] dq[$];
  logic [45:0] e;
  int          failures = 0, num_checks = 0, seed = 32'hd248f93f, i, j;
  always #50 sys_clk = ~sys_clk;
  cod_operand_decode u_dut (.*);
  cod_mem_model u_mem (.*);
  task automatic chk(input string nm, input logic [63:0] s, x);
    num_checks++;
    if (s !== x)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input logic w, r, input logic [15:0] a, d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [15:0] a, x);
    rq.push_back(x);
    cyc(1'b0, 1'b1, a, 16'h0);
  endtask
  task automatic alu(input logic [15:0] r, input logic c, o, y);
    reg_rd <= 1'b0;
    alu_result <= r;
    alu_carry <= c;
    alu_ovf <= o;
    alu_byte <= y;
    alu_done <= 1'b1;
    @(posedge sys_clk);
    alu_done <= 1'b0;
  endtask
  task automatic dec(input logic [15:0] w, input logic [7:0] m, input logic [1:0] mk,
                     input logic [15:0] sx, dx, input int n = 0,
                     input logic [15:0] x1 = 16'h0, x2 = 16'h0);
    if (n > 0) u_mem.words.push_back(x1);
    if (n > 1) u_mem.words.push_back(x2);
    dq.push_back({mk, w[15:12], m, sx, dx});
    instr_word <= w;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    for (i = 0; i < 30 && exec_go !== 1'b1; i++) @(posedge sys_clk);
    if (exec_go !== 1'b1)
    begin
      failures++;
      close_out;
    end
    @(posedge sys_clk);
  endtask
  always @(posedge sys_clk)
  begin
    rd_q <= reg_rd;
    if (rd_q && rq.size() > 0) chk("rdata", reg_rdata, rq.pop_front());
    if (exec_go === 1'b1)
    begin
      e = dq.pop_front();
      chk("mode", {opcode, src_mode, dst_mode, src_byte, dst_byte}, e[43:32]);
      if (e[45]) chk("src", (e[39:37] == 3'h0) ? src_reg_addr : src_ea, e[31:16]);
      if (e[44]) chk("dst", (e[36:34] == 3'h0) ? dst_reg_addr : dst_ea, e[15:0]);
    end
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    chk("fetch", fetch_addr, 16'hfff0);
    rd(16'hc002, 16'h0100);
    rd(16'h0400, 16'h0000);
    b = $random(seed);
    cyc(1'b1, 1'b0, 16'hc002, b);
    rd(16'hc002, b);
    cyc(1'b1, 1'b0, 16'hc000, 16'hffff);
    cyc(1'b0, 1'b0, 16'h0, 16'h0);
    ie_set <= 1'b1;
    alu(16'h0000, 1'b1, 1'b1, 1'b0);
    ie_set <= 1'b0;
    rd(16'hc000, 16'h0013);
    chk("ovf", ovf_flag, 1'b1);
    alu(16'h8000, 1'b0, 1'b0, 1'b0);
    rd(16'hc000, 16'h0018);
    chk("ovf", ovf_flag, 1'b0);
    ie_clr <= 1'b1;
    alu(16'h0080, 1'b0, 1'b0, 1'b1);
    ie_clr <= 1'b0;
    rd(16'hc000, 16'h0008);
    cyc(1'b0, 1'b0, 16'h0, 16'h0);
    for (j = 0; j < 4; j++)
    begin
      r1 = $random(seed);
      dec({4'h1, 2'b00, r1[3:0], 2'b00, r1[7:4]}, 8'h00, 2'b11,
          (b & 16'hffe0) | {11'h0, r1[3:0], 1'b0}, (b & 16'hffe0) | {11'h0, r1[7:4], 1'b0});
    end
    r1 = $random(seed);
    r2 = $random(seed);
    u_mem.lag = 3;
    dec({4'h2, 6'h1f, 6'h27}, {3'h1, 3'h2, 2'b00}, 2'b11, r1, r2, 2, r1, r2);
    u_mem.lag = 0;
    dec({4'h3, 6'h2f, 6'h2f}, {3'h2, 3'h2, 2'b11}, 2'b11, r2, r1, 2, r2, r1);
    dec({4'h4, 6'h1a, 6'h30}, {3'h3, 3'h5, 2'b10}, 2'b01, 16'h0, 16'h0010, 1, 16'h0020);
    dec({4'h5, 6'h02, 6'h21}, {3'h0, 3'h4, 2'b00}, 2'b10, (b & 16'hffe0) | 16'h4, 16'h0);
    dec({4'h6, 6'h05, 6'h29}, {3'h0, 3'h4, 2'b01}, 2'b10, (b & 16'hffe0) | 16'ha, 16'h0);
    op_wr <= 1'b1;
    dec({4'h7, 6'h00, 6'h17}, {3'h0, 3'h3, 2'b00}, 2'b01, 16'h0, 16'hffee);
    op_wr <= 1'b0;
    dec({4'h8, 6'h00, 6'h17}, {3'h0, 3'h3, 2'b00}, 2'b01, 16'h0, 16'hfff0);
    repeat (3) @(posedge sys_clk);
    chk("pending", dq.size(), 64'h0);
    close_out;
  end
endmodule
